// file: hw/lcr_pkg.sv
/*
 package for the cache bus response block: timing counts and state types.
 assumes a single 100 MHz system clock.
*/
package lcr_pkg;
   localparam int LCR_BEATS = 4;
   localparam logic [2:0] LCR_LAST_BEAT = 3'h4;
   localparam int LCR_BR_DELAY = 2;
   localparam logic [1:0] LCR_BR_DELAY_CNT = 2'h2;
   typedef enum logic [1:0] {LCR_IDLE, LCR_HIT, LCR_MEM} lcr_tenure_type;
   typedef enum logic [2:0] {LCR_SN_IDLE, LCR_SN_RETRY, LCR_SN_WIN, LCR_SN_BRWIN,
                             LCR_SN_GRANT, LCR_SN_CPUWB} lcr_snoop_type;
endpackage

// file: hw/lcr_sync.sv
/*
 three-stage synchroniser for one pin input; a change is taken when stages two and three agree.
 assumes clk is the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module lcr_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic din,
   output logic dout
);
   logic s1, s2, s3;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         dout <= 1'b0;
      end else if (ce) begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) dout <= s2;
      end
   end
endmodule // lcr_sync
`default_nettype wire

// file: hw/lcr_bus_response.sv
/*
 transaction response logic of a look-aside cache on a shared processor bus:
 address acknowledge, claim, data beats, castout buffer control and snoop retry.
 assumes tag lookup results (hit, dirty) arrive with ts; bus pins are active high here.
*/
`timescale 1ns/100ps
`default_nettype none
module lcr_bus_response
   import lcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic ts,
   input wire logic ts_is_write,
   input wire logic ts_is_snoop,
   input wire logic ts_is_burst,
   input wire logic write_through_attribute,
   input wire logic lookup_hit,
   input wire logic lookup_dirty,
   input wire logic ta_in,
   input wire logic aack_in,
   input wire logic processor_data_bus_grant,
   input wire logic processor_bus_request,
   input wire logic cache_bus_grant_pin,
   output logic aack_out,
   output logic aack_oe,
   output logic claim,
   output logic ta_out,
   output logic ta_oe,
   output logic artry_out,
   output logic artry_oe,
   output logic cache_bus_request,
   output logic castout_load,
   output logic castout_start,
   output logic line_update,
   output logic line_invalidate
);
   lcr_tenure_type tenure, next_tenure;
   lcr_snoop_type snoop, next_snoop;
   logic cache_bus_grant;
   logic [2:0] beat;
   logic pend, pend_claim, aack_done;
   logic [1:0] br_cnt;
   logic victim_pending, castout_held, snoop_write, cpu_wb_seen;

   lcr_sync u_grant_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .din(cache_bus_grant_pin),
      .dout(cache_bus_grant)
   );

   // wt write hits and clean-victim misses stay silent
   wire is_wt = ts & write_through_attribute;
   wire silent = (is_wt & ts_is_write & lookup_hit) | (~lookup_hit & ~lookup_dirty);
   wire cpu_ts = ts & ~ts_is_snoop;
   wire hit_ts = cpu_ts & lookup_hit & ~silent;
   wire dirty_miss = cpu_ts & ~lookup_hit & lookup_dirty & ts_is_burst;
   wire snoop_dirty = ts & ts_is_snoop & lookup_hit & lookup_dirty & (snoop == LCR_SN_IDLE);
   wire busy = tenure != LCR_IDLE;
   wire hit_beat = (tenure == LCR_HIT) & ta_out;
   wire mem_beat = (tenure == LCR_MEM) & ta_in;
   wire last_hit = hit_beat & (beat == LCR_LAST_BEAT - 3'h1);
   // registered aack must be launched on the third beat to stand beside the fourth
   wire pre_last_hit = hit_beat & (beat == LCR_LAST_BEAT - 3'h2);
   wire last_mem = mem_beat & (beat == LCR_LAST_BEAT - 3'h1);
   wire tenure_end = last_hit | last_mem;
   // data grant must be qualified before driving data
   wire grant_ok = processor_data_bus_grant;
   logic tenure_end_q;
   wire start_hit = (hit_ts & ~busy) | (pend & pend_claim & tenure_end_q);
   // second tenure's aack: with fourth hit ta, or cycle after fourth memory ta
   wire pend_aack = pend & ~aack_done & (pre_last_hit | last_mem);
   wire first_aack = hit_ts & ~busy & ~pend;
   wire drive_ta = (tenure == LCR_HIT) & (ta_out | grant_ok | beat != 3'h0);

   always_comb begin
      next_tenure = tenure;
      if (tenure_end) next_tenure = LCR_IDLE;
      if (cpu_ts & ~busy & ~lookup_hit) next_tenure = LCR_MEM;
      if (hit_ts & ~busy) next_tenure = LCR_HIT;
      if (pend & tenure_end_q & tenure == LCR_IDLE) next_tenure = pend_claim ? LCR_HIT : LCR_MEM;
   end

   always_comb begin
      next_snoop = snoop;
      unique case (snoop)
         LCR_SN_IDLE: if (snoop_dirty) next_snoop = LCR_SN_RETRY;
         LCR_SN_RETRY: if (aack_in) next_snoop = LCR_SN_WIN;
         LCR_SN_WIN: next_snoop = LCR_SN_BRWIN;
         LCR_SN_BRWIN: next_snoop = processor_bus_request ? LCR_SN_CPUWB : LCR_SN_GRANT;
         LCR_SN_GRANT: if (cache_bus_grant) next_snoop = LCR_SN_IDLE;
         LCR_SN_CPUWB: if (cpu_wb_seen) next_snoop = LCR_SN_IDLE;
         default: next_snoop = LCR_SN_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tenure <= LCR_IDLE;
         snoop <= LCR_SN_IDLE;
         beat <= 3'h0;
         pend <= 1'b0;
         pend_claim <= 1'b0;
         aack_done <= 1'b0;
         tenure_end_q <= 1'b0;
      end else if (ce) begin
         tenure <= next_tenure;
         snoop <= next_snoop;
         tenure_end_q <= tenure_end;
         if (tenure_end | next_tenure == LCR_IDLE) beat <= 3'h0;
         else if (hit_beat | mem_beat) beat <= beat + 3'h1;
         if (cpu_ts & busy & ~pend) begin
            pend <= 1'b1;
            pend_claim <= hit_ts;
            aack_done <= ~hit_ts;
         end else if (pend & tenure_end_q) pend <= 1'b0;
         if (pend_aack) aack_done <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aack_out <= 1'b0;
         aack_oe <= 1'b0;
         claim <= 1'b0;
         ta_out <= 1'b0;
         ta_oe <= 1'b0;
         artry_out <= 1'b0;
         artry_oe <= 1'b0;
      end else if (ce) begin
         aack_out <= first_aack | pend_aack;
         aack_oe <= first_aack | pend_aack | aack_out;
         claim <= hit_ts | (claim & ~aack_out) | aack_out & claim & 1'b0;
         ta_out <= drive_ta & ~last_hit | (start_hit & grant_ok);
         ta_oe <= (tenure == LCR_HIT) | start_hit;
         artry_out <= next_snoop == LCR_SN_RETRY | next_snoop == LCR_SN_WIN;
         artry_oe <= next_snoop == LCR_SN_RETRY | next_snoop == LCR_SN_WIN | artry_out;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         br_cnt <= 2'h0;
         cache_bus_request <= 1'b0;
         victim_pending <= 1'b0;
         castout_held <= 1'b0;
         castout_load <= 1'b0;
         castout_start <= 1'b0;
         snoop_write <= 1'b0;
         cpu_wb_seen <= 1'b0;
         line_update <= 1'b0;
         line_invalidate <= 1'b0;
      end else if (ce) begin
         if (dirty_miss) br_cnt <= LCR_BR_DELAY_CNT - 2'h1;
         else if (br_cnt != 2'h0) br_cnt <= br_cnt - 2'h1;
         if (snoop_dirty) snoop_write <= ts_is_write;
         // two clocks after ts for a dirty victim; same cycle as retry for snoop
         if ((br_cnt == 2'h1) | snoop_dirty) cache_bus_request <= 1'b1;
         else if ((snoop == LCR_SN_BRWIN & processor_bus_request) | castout_start) cache_bus_request <= 1'b0;
         if (dirty_miss) victim_pending <= 1'b1;
         castout_load <= victim_pending & (tenure == LCR_MEM) & ta_in;
         if (victim_pending & last_mem) begin
            victim_pending <= 1'b0;
            castout_held <= 1'b1;
         end
         // castout only after processor tenure ends; a grant while cpu writes back is ignored
         // one-cycle pulse: held clears one edge after castout_start rises, so block a repeat
         castout_start <= castout_held & ~castout_start & cache_bus_grant & ~busy & snoop != LCR_SN_CPUWB;
         if (castout_start) castout_held <= 1'b0;
         cpu_wb_seen <= (snoop == LCR_SN_CPUWB) & cpu_ts & ts_is_write;
         line_update <= cpu_wb_seen & ~snoop_write;
         line_invalidate <= cpu_wb_seen & snoop_write;
         if (cpu_wb_seen) castout_held <= 1'b0;
      end
   end

   ack_after_fourth_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce & pend & ~aack_done & last_mem |=> aack_out) else $error("pipelined aack not after memory tenure");
   aack_with_beat_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce & pend & ~aack_done & pre_last_hit |=> aack_out & ta_out) else $error("pipelined aack not with fourth beat");
   br_two_clk_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce & dirty_miss & snoop == LCR_SN_IDLE ##1 ce |=> cache_bus_request) else $error("bus request late");
   retry_req_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce & snoop_dirty |=> artry_out & cache_bus_request) else $error("retry and request not together");
   cpu_req_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce & snoop == LCR_SN_BRWIN & processor_bus_request & ~dirty_miss |=> ~cache_bus_request)
      else $error("request kept after cpu request");
   castout_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      castout_start |-> $past(tenure) != LCR_MEM) else $error("castout during processor tenure");
   no_silent_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce & cpu_ts & silent & ~busy & ~pend |=> ~claim & ~ta_oe) else $error("silent op drove bus");
   ta_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce & first_aack & ~grant_ok |=> ~ta_out) else $error("ta without data grant");
   cover_hit_c: cover property (@(posedge clk) first_aack);
   cover_pipe_c: cover property (@(posedge clk) pend_aack);
   cover_snoop_c: cover property (@(posedge clk) snoop == LCR_SN_CPUWB);
endmodule // lcr_bus_response
`default_nettype wire

// file: verif/lcr_partner.sv
/*
 far-side model: memory controller serving transfers the cache leaves unclaimed, aack for snoops.
 assumes active-high bus levels, one clock, at most one memory tenure at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module lcr_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ts,
   input wire logic ts_is_snoop,
   input wire logic claim,
   output logic mem_aack,
   output logic mem_ta
);
   logic pend;
   logic snp;
   logic [2:0] cnt;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 1'b0;
         snp <= 1'b0;
         cnt <= 3'h0;
      end else begin
         pend <= ts;
         if (ts && cnt == 3'h0) snp <= ts_is_snoop;
         if (pend && cnt == 3'h0 && (snp || !claim)) cnt <= 3'h1;
         else if (cnt != 3'h0) cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
      end
   end
   assign mem_aack = (cnt == 3'h1);
   // slow 4-1-1-1 beats; a released line reads negated
   assign mem_ta = !snp && (cnt >= 3'h2);
endmodule // lcr_partner
`default_nettype wire

// file: verif/lcr_bus_response_tb.sv
/*
 testbench for the cache bus response block: hand-written scenarios on recorded output patterns.
 assumes the partner model serves memory tenures; bus lines are the or of all drivers.
*/
`timescale 1ns/100ps
`default_nettype none
module lcr_bus_response_tb;
   import lcr_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, ts = 1'b0, wr = 1'b0, snp = 1'b0, hit = 1'b0;
   logic dirty = 1'b0, wt = 1'b0, dgnt = 1'b1, cpu_req = 1'b0, bg = 1'b0;
   logic [15:0] l_h;
   logic aack_out, aack_oe, claim, ta_out, ta_oe, artry_out, artry_oe, cache_bus_request;
   logic castout_load, castout_start, line_update, line_invalidate, mem_aack, mem_ta;
   logic [15:0] a_h, t_h, r_h, o_h, c_h, z_h;
   int bad_count = 0, checks_done = 0, cyc = 0;
   always #5 clk = ~clk;
   lcr_bus_response lcr_bus_response_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .ts(ts),
      .ts_is_write(wr), .ts_is_snoop(snp), .ts_is_burst(1'b1), .write_through_attribute(wt),
      .lookup_hit(hit), .lookup_dirty(dirty), .ta_in(ta_out | mem_ta), .aack_in(aack_out | mem_aack),
      .processor_data_bus_grant(dgnt), .processor_bus_request(cpu_req), .cache_bus_grant_pin(bg),
      .aack_out(aack_out), .aack_oe(aack_oe), .claim(claim), .ta_out(ta_out), .ta_oe(ta_oe),
      .artry_out(artry_out), .artry_oe(artry_oe), .cache_bus_request(cache_bus_request),
      .castout_load(castout_load), .castout_start(castout_start), .line_update(line_update),
      .line_invalidate(line_invalidate));
   lcr_partner lcr_partner_inst (.clk(clk), .rst_n(rst_n), .ts(ts), .ts_is_snoop(snp),
      .claim(claim), .mem_aack(mem_aack), .mem_ta(mem_ta));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // generous ceiling: six scenarios of about twenty cycles each
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic do_reset();
      @(negedge clk);
      rst_n = 1'b0;
      {wr, snp, dirty, wt, cpu_req, dgnt, bg} = 7'b0000010;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
   endtask
   // index i of each pattern is the cycle after the i-th negedge; ts_pat bit i starts a transfer there
   task automatic run(input logic [15:0] ts_pat, input logic [15:0] hit_pat);
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         {a_h[i], t_h[i], r_h[i], o_h[i], c_h[i]} = {aack_out, ta_out, cache_bus_request, artry_out, castout_start};
         z_h[i] = aack_oe | ta_oe | artry_oe | claim | cache_bus_request;
         l_h[i] = castout_load;
         ts = ts_pat[i];
         hit = hit_pat[i];
         if (i == 1) dgnt = 1'b1;
      end
   endtask
   task automatic t_hit_pipe();
      do_reset();
      run(16'h0005, 16'h0005);
      check(a_h & 16'h003f, 16'h0012, "pipelined aack");
      check(t_h & 16'h001f, 16'h001e, "hit beats");
      $display("hit_pipe done");
   endtask
   task automatic t_miss_hit();
      do_reset();
      run(16'h0005, 16'h0004);
      check(a_h & 16'h00ff, 16'h0080, "aack after memory tenure");
      check(z_h & 16'h0006, 16'h0000, "clean miss quiet");
      $display("miss_hit done");
   endtask
   task automatic t_write_through();
      do_reset();
      {wr, wt} = 2'b11;
      run(16'h0001, 16'h0001);
      check(z_h & 16'h00fe, 16'h0000, "write-through hit quiet");
      $display("write_through done");
   endtask
   task automatic t_dirty_miss();
      do_reset();
      dirty = 1'b1;
      bg = 1'b1;
      run(16'h0001, 16'h0000);
      check(r_h & 16'h0006, 16'h0004, "request two after ts");
      check(c_h & 16'h007f, 16'h0000, "castout waits");
      check(c_h & 16'h03ff, 16'h0100, "castout once after tenure");
      check(l_h & 16'h01ff, 16'h00f0, "victim moves with fill beats");
      $display("dirty_miss done");
   endtask
   task automatic t_snoop();
      do_reset();
      {snp, dirty, cpu_req} = 3'b111;
      run(16'h0001, 16'h0001);
      check(o_h & 16'h001e, 16'h000e, "retry window");
      check(r_h & 16'h0022, 16'h0002, "request with retry, dropped");
      $display("snoop done");
   endtask
   task automatic t_unparked();
      do_reset();
      dgnt = 1'b0;
      run(16'h0001, 16'h0001);
      check(a_h & 16'h0002, 16'h0002, "aack without grant");
      check(t_h & 16'h003e, 16'h003c, "gated beats");
      $display("unparked done");
   endtask
   initial begin
      t_hit_pipe();
      t_miss_hit();
      t_write_through();
      t_dirty_miss();
      t_snoop();
      t_unparked();
      give_verdict();
   end
endmodule // lcr_bus_response_tb
`default_nettype wire
